/* hdl/dbg_exc_pkg.sv */
// Package with the constants and carriers of the debug exception condition unit.
package dbg_exc_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_SLOT0 = 4'h0;
  localparam logic [3:0] ADDR_SLOT1 = 4'h1;
  localparam logic [3:0] ADDR_SLOT2 = 4'h2;
  localparam logic [3:0] ADDR_SLOT3 = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_CONTROL = 4'h7;
  localparam logic [3:0] ADDR_RFLAG = 4'h8;

  // ---------------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------------
  localparam int ST_BD = 13;
  localparam int ST_BS = 14;
  localparam int ST_BT = 15;
  localparam int CT_GD = 13;
  localparam int CT_TYPE_LSB = 16;
  localparam int SLOTS = 4;
  localparam logic [31:0] STATUS_RESET = 32'hFFFF0FF0;
  localparam logic [31:0] CONTROL_RESET = 32'h00000400;
  localparam logic [31:0] STATUS_WMASK = 32'h0000E00F;
  localparam logic [31:0] CONTROL_WMASK = 32'hFFFF23FF;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0] TYPE_EXEC = 2'h0;
  localparam logic [1:0] TYPE_WRITE = 2'h1;
  localparam logic [1:0] TYPE_IO = 2'h2;
  localparam logic [1:0] TYPE_RW = 2'h3;
  localparam logic [1:0] LEN_1 = 2'h0;
  localparam logic [1:0] LEN_2 = 2'h1;
  localparam logic [1:0] LEN_8 = 2'h2;
  localparam logic [1:0] LEN_4 = 2'h3;
  localparam logic [7:0] VEC_DEBUG = 8'h01;
  localparam logic [7:0] VEC_SOFT_BP = 8'h03;

  // Kind of event handler that the core is entering.
  typedef enum logic [2:0] {
    EV_NONE, EV_FAULT, EV_IBP_FAULT, EV_INTR, EV_TRAP, EV_SOFT_INT
  } event_kind_e;

  // One data or port access reported by the core while an instruction executes.
  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_write;
    logic [31:0] addr;
    logic [3:0] size;
  } access_s;

  // Exception request towards the core.
  typedef struct packed {
    logic valid;
    logic fault;
    logic [7:0] vector;
  } exc_req_s;

endpackage : dbg_exc_pkg

/* hdl/dbg_exc_unit.sv */
// Debug exception condition unit: breakpoints, status, resume flag handling.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps

// Function
// - Debug on vector 1, soft breakpoint vector 3
// - Instruction and general detect fault, others trap
// - Enabled slot match sets hit; type selects
// - Guarded debug register access: flag, fault
// - Step and task switch set own flags
// - One delivery reports all simultaneous conditions
// - Execute match faults before instruction runs
// - Instruction breakpoint wins over other exceptions
// - Stack segment load inhibits next instruction breakpoint
// - Resume flag suppresses instruction breakpoints
// - Resume flag cleared at instruction start
// - Task switch, wide return load resume flag
// - Non breakpoint fault pushes resume one
// - Interrupt mid repeat string pushes one
// - Trap mid repeat string pushes one
// - Otherwise push current resume flag value
// - Only wide return or task switch restores
// - Resume flag leaves data breakpoints active
// - Data or port match traps after completion
// - Write completes before its trap
// - Port string traps after first iteration
// - Length field masks low address bits
// - Any touched byte in range matches
module dbg_exc_unit #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Instruction boundary from the core
  input wire logic insn_start,
  input wire logic [ADDR_W-1:0] insn_addr,
  input wire logic ss_load_shadow,
  input wire logic dbg_reg_access,
  input wire logic insn_done,
  input wire logic rep_not_last,
  input wire logic step_trap,
  input wire logic task_trap,
  input wire logic dbg_exc_accept,
  // Data and port accesses
  input wire dbg_exc_pkg::access_s acc,
  // Resume flag load and handler entry
  input wire logic rf_load,
  input wire logic rf_load_value,
  input wire dbg_exc_pkg::event_kind_e entry_kind,
  // Outputs to the core
  output dbg_exc_pkg::exc_req_s exc_req,
  output logic resume_flag,
  output logic pushed_resume_flag,
  output logic reg_write_blocked
);

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  // The slot registers and the range arithmetic are 32 bits wide, so no other width fits.
  if (ADDR_W != 32) begin : g_bad_width
    $error("dbg_exc_unit supports a 32-bit instruction address only");
  end

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [31:0] bp_addr_slot [dbg_exc_pkg::SLOTS];
  logic [31:0] debug_status_reg;
  logic [31:0] debug_control_reg;
  logic [3:0] slot_hit_flag;
  logic [3:0] pend_data_reg;
  logic general_detect_flag;
  logic single_step_flag;
  logic task_switch_flag;
  logic inhibit_reg;
  logic gd_fault;
  logic [3:0] ibp_hit;
  logic [3:0] dbp_hit;

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  // Mask of low address bits ignored for a given length field.
  function automatic logic [31:0] len_mask(input logic [1:0] len);
    unique case (len)
      dbg_exc_pkg::LEN_1: len_mask = 32'hFFFFFFFF;
      dbg_exc_pkg::LEN_2: len_mask = 32'hFFFFFFFE;
      dbg_exc_pkg::LEN_8: len_mask = 32'hFFFFFFF8;
      dbg_exc_pkg::LEN_4: len_mask = 32'hFFFFFFFC;
    endcase
  endfunction : len_mask

  // True when any byte of [a, a+size) falls in the masked slot range.
  function automatic logic range_hit(input logic [31:0] base, input logic [1:0] len,
                                     input logic [31:0] a, input logic [3:0] size);
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] last;
    lo = base & len_mask(len);
    hi = lo | ~len_mask(len);
    last = a + {28'h0000000, size} - 32'h00000001;
    range_hit = (size != 4'h0) && (a <= hi) && (last >= lo);
  endfunction : range_hit

  function automatic logic slot_on(input logic [31:0] ctl, input int n);
    slot_on = ctl[2*n] | ctl[2*n+1];
  endfunction : slot_on

  function automatic logic [1:0] slot_type(input logic [31:0] ctl, input int n);
    slot_type = ctl[dbg_exc_pkg::CT_TYPE_LSB+4*n +: 2];
  endfunction : slot_type

  function automatic logic [1:0] slot_len(input logic [31:0] ctl, input int n);
    slot_len = ctl[dbg_exc_pkg::CT_TYPE_LSB+4*n+2 +: 2];
  endfunction : slot_len

  // ---------------------------------------------------------------------------
  // Match logic
  // ---------------------------------------------------------------------------
  always_comb begin
    logic tmatch;
    tmatch = 1'b0;
    for (int n = 0; n < dbg_exc_pkg::SLOTS; n++) begin
      // Instruction slots compare the first byte only, with no length mask.
      ibp_hit[n] = insn_start && slot_on(debug_control_reg, n) &&
                   slot_type(debug_control_reg, n) == dbg_exc_pkg::TYPE_EXEC &&
                   insn_addr == bp_addr_slot[n] &&
                   !resume_flag && !inhibit_reg;
      unique case (slot_type(debug_control_reg, n))
        dbg_exc_pkg::TYPE_WRITE: tmatch = !acc.is_io && acc.is_write;
        dbg_exc_pkg::TYPE_IO: tmatch = acc.is_io;
        dbg_exc_pkg::TYPE_RW: tmatch = !acc.is_io;
        dbg_exc_pkg::TYPE_EXEC: tmatch = 1'b0;
      endcase
      // The resume flag is not consulted here.
      dbp_hit[n] = acc.valid && slot_on(debug_control_reg, n) && tmatch &&
                   range_hit(bp_addr_slot[n], slot_len(debug_control_reg, n),
                             acc.addr, acc.size);
    end
  end

  assign gd_fault = insn_start && dbg_reg_access && debug_control_reg[dbg_exc_pkg::CT_GD];

  // ---------------------------------------------------------------------------
  // Register writes and breakpoint slots
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int n = 0; n < dbg_exc_pkg::SLOTS; n++) begin
        bp_addr_slot[n] <= 32'h00000000;
      end
      debug_control_reg <= dbg_exc_pkg::CONTROL_RESET;
    end else if (reg_wr && !gd_fault && !debug_control_reg[dbg_exc_pkg::CT_GD]) begin
      if (reg_addr <= dbg_exc_pkg::ADDR_SLOT3) begin
        bp_addr_slot[reg_addr[1:0]] <= reg_wdata;
      end else if (reg_addr == dbg_exc_pkg::ADDR_CONTROL) begin
        debug_control_reg <= (reg_wdata & dbg_exc_pkg::CONTROL_WMASK) |
                             dbg_exc_pkg::CONTROL_RESET;
      end
    end
  end

  // A write attempted while general detection is armed is dropped and reported.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_write_blocked <= 1'b0;
    end else begin
      reg_write_blocked <= reg_wr && debug_control_reg[dbg_exc_pkg::CT_GD];
    end
  end

  // ---------------------------------------------------------------------------
  // Pending data breakpoints and port string handling
  // ---------------------------------------------------------------------------
  // Hits are held until the instruction, or the current string iteration,
  // completes, so the store has already reached memory when the trap fires.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_data_reg <= 4'h0;
    end else begin
      // Each string iteration ends with its own completion pulse, so a port
      // string traps after its first iteration and a memory one after the hit.
      if (insn_done) begin
        pend_data_reg <= 4'h0;
      end else begin
        pend_data_reg <= pend_data_reg | dbp_hit;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Status register and exception request
  // ---------------------------------------------------------------------------
  always_comb begin
    slot_hit_flag = ibp_hit | (insn_done ? (pend_data_reg | dbp_hit) : 4'h0);
    general_detect_flag = gd_fault;
    single_step_flag = insn_done && step_trap;
    task_switch_flag = task_trap;
  end

  // Hardware sets win over a software write in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      debug_status_reg <= dbg_exc_pkg::STATUS_RESET;
    end else begin
      logic [31:0] base;
      base = debug_status_reg;
      if (reg_wr && reg_addr == dbg_exc_pkg::ADDR_STATUS &&
          !debug_control_reg[dbg_exc_pkg::CT_GD]) begin
        base = (reg_wdata & dbg_exc_pkg::STATUS_WMASK) | dbg_exc_pkg::STATUS_RESET;
      end
      base[3:0] = base[3:0] | slot_hit_flag;
      base[dbg_exc_pkg::ST_BD] = base[dbg_exc_pkg::ST_BD] | general_detect_flag;
      base[dbg_exc_pkg::ST_BS] = base[dbg_exc_pkg::ST_BS] | single_step_flag;
      base[dbg_exc_pkg::ST_BT] = base[dbg_exc_pkg::ST_BT] | task_switch_flag;
      debug_status_reg <= base;
    end
  end

  // Fault requests take precedence; the request holds until the core accepts.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exc_req <= '0;
    end else if (|ibp_hit || gd_fault) begin
      exc_req.valid <= 1'b1;
      exc_req.fault <= 1'b1;
      exc_req.vector <= dbg_exc_pkg::VEC_DEBUG;
    end else if ((|slot_hit_flag) || single_step_flag || task_switch_flag) begin
      exc_req.valid <= 1'b1;
      exc_req.fault <= 1'b0;
      exc_req.vector <= dbg_exc_pkg::VEC_DEBUG;
    end else if (dbg_exc_accept) begin
      // The class bit is dropped too, so an idle request never looks like a fault.
      exc_req.valid <= 1'b0;
      exc_req.fault <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Resume flag
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resume_flag <= 1'b0;
      inhibit_reg <= 1'b0;
    end else begin
      if (rf_load) begin
        resume_flag <= rf_load_value;
      end else if (insn_start) begin
        resume_flag <= 1'b0;
      end
      if (insn_start) begin
        inhibit_reg <= ss_load_shadow;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pushed_resume_flag <= 1'b0;
    end else begin
      unique case (entry_kind)
        dbg_exc_pkg::EV_FAULT: pushed_resume_flag <= 1'b1;
        dbg_exc_pkg::EV_INTR: pushed_resume_flag <= rep_not_last | resume_flag;
        dbg_exc_pkg::EV_TRAP: pushed_resume_flag <= rep_not_last | resume_flag;
        dbg_exc_pkg::EV_IBP_FAULT: pushed_resume_flag <= resume_flag;
        dbg_exc_pkg::EV_SOFT_INT: pushed_resume_flag <= resume_flag;
        dbg_exc_pkg::EV_NONE: pushed_resume_flag <= pushed_resume_flag;
        default: pushed_resume_flag <= pushed_resume_flag;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr <= dbg_exc_pkg::ADDR_SLOT3) begin
        reg_rdata <= bp_addr_slot[reg_addr[1:0]];
      end else if (reg_addr == dbg_exc_pkg::ADDR_STATUS) begin
        reg_rdata <= debug_status_reg;
      end else if (reg_addr == dbg_exc_pkg::ADDR_CONTROL) begin
        reg_rdata <= debug_control_reg;
      end else if (reg_addr == dbg_exc_pkg::ADDR_RFLAG) begin
        reg_rdata <= {31'h00000000, resume_flag};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule : dbg_exc_unit

/* sim/dbg_exc_unit_properties.sv */
// Concurrent checks on the ports of the debug exception condition unit.
`timescale 1ns/1ps
module dbg_exc_unit_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Requests from the core and the register port
  input wire logic reg_wr,
  input wire logic insn_start,
  input wire logic dbg_reg_access,
  input wire logic rep_not_last,
  input wire logic rf_load,
  input wire logic rf_load_value,
  input wire dbg_exc_pkg::event_kind_e entry_kind,
  // Answers of the unit
  input wire dbg_exc_pkg::exc_req_s exc_req,
  input wire logic resume_flag,
  input wire logic pushed_resume_flag,
  input wire logic reg_write_blocked
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_vec; exc_req.valid |-> exc_req.vector == dbg_exc_pkg::VEC_DEBUG; endproperty
  a_vec: assert property (p_vec) else $error("debug request on wrong vector");
  property p_flt; $rose(exc_req.valid) && exc_req.fault |-> $past(insn_start); endproperty
  a_flt: assert property (p_flt) else $error("fault raised away from instruction start");
  property p_ibp_off;
    insn_start && resume_flag && !dbg_reg_access && !exc_req.valid |=> !exc_req.fault;
  endproperty
  a_ibp_off: assert property (p_ibp_off) else $error("fault while resume set");
  property p_rf_clr; insn_start && !rf_load |=> !resume_flag; endproperty
  a_rf_clr: assert property (p_rf_clr) else $error("resume flag not cleared");
  property p_rf_ld; rf_load |=> resume_flag == $past(rf_load_value); endproperty
  a_rf_ld: assert property (p_rf_ld) else $error("resume flag load lost");
  property p_psh_flt; entry_kind == dbg_exc_pkg::EV_FAULT |=> pushed_resume_flag; endproperty
  a_psh_flt: assert property (p_psh_flt) else $error("fault entry pushed zero");
  property p_psh_rep;
    (entry_kind == dbg_exc_pkg::EV_INTR || entry_kind == dbg_exc_pkg::EV_TRAP) && rep_not_last
      |=> pushed_resume_flag;
  endproperty
  a_psh_rep: assert property (p_psh_rep) else $error("mid repeat entry pushed zero");
  property p_psh_ibp;
    entry_kind == dbg_exc_pkg::EV_IBP_FAULT |=> pushed_resume_flag == $past(resume_flag);
  endproperty
  a_psh_ibp: assert property (p_psh_ibp) else $error("breakpoint entry pushed wrong");
  property p_blk; reg_write_blocked |-> $past(reg_wr); endproperty
  a_blk: assert property (p_blk) else $error("blocked pulse without a write");
  c_flt: cover property ($rose(exc_req.valid) && exc_req.fault);
  c_trap: cover property ($rose(exc_req.valid) && !exc_req.fault);
  c_blk: cover property (reg_write_blocked);
endmodule : dbg_exc_unit_chk

bind dbg_exc_unit dbg_exc_unit_chk u_chk (.clk_sys, .rst_n, .reg_wr, .insn_start,
  .dbg_reg_access, .rep_not_last, .rf_load, .rf_load_value, .entry_kind, .exc_req,
  .resume_flag, .pushed_resume_flag, .reg_write_blocked);

/* sim/dbg_exc_unit_tb.sv */
// Self-checking testbench of the debug exception condition unit.
`timescale 1ns/1ps
module dbg_exc_unit_tb;
  logic clk_sys, rst_n, reg_wr, reg_rd, insn_start, ss_load_shadow, dbg_reg_access;
  logic insn_done, rep_not_last, step_trap, task_trap, dbg_exc_accept, rf_load;
  logic rf_load_value, resume_flag, pushed_resume_flag, reg_write_blocked;
  logic rd_d, ent_d, exc_d, r, p, e;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, insn_addr, base;
  dbg_exc_pkg::access_s acc;
  dbg_exc_pkg::event_kind_e entry_kind;
  dbg_exc_pkg::exc_req_s exc_req;
  logic [33:0] q[$];
  int errors, n_tests, cyc;

  dbg_exc_unit u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .insn_start, .insn_addr, .ss_load_shadow, .dbg_reg_access, .insn_done, .rep_not_last,
    .step_trap, .task_trap, .dbg_exc_accept, .acc, .rf_load, .rf_load_value, .entry_kind,
    .exc_req, .resume_flag, .pushed_resume_flag, .reg_write_blocked);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------------------
  // Result watcher and closing
  // ---------------------------------------------------------------------------
  task automatic take(input logic [33:0] got);
    logic [33:0] w;
    w = q.size() ? q.pop_front() : 34'h3FFFFFFFF;
    n_tests++;
    if (w !== got) begin
      errors++;
      $display("FAIL %0t got %h want %h", $time, got, w);
    end
  endtask : take

  task automatic give_verdict();
    if (q.size() != 0) begin
      errors++;
      $display("FAIL %0t %0d expected results never seen", $time, q.size());
    end
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    ent_d <= entry_kind != dbg_exc_pkg::EV_NONE;
    cyc++;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end

  // Results are sampled mid-cycle so that registered outputs have settled.
  always @(negedge clk_sys) begin
    exc_d <= exc_req.valid;
    if (rd_d) take({2'h0, reg_rdata});
    if (exc_req.valid && !exc_d) take({2'h1, 23'h0, exc_req.fault, exc_req.vector});
    if (ent_d) take({2'h2, 31'h0, pushed_resume_flag});
    if (reg_write_blocked) take({2'h3, 32'h1});
  end

  // ---------------------------------------------------------------------------
  // Bus and core drivers
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    q.push_back({2'h0, x});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  // Kind 2 expects a fault at the start, 1 a trap after completion, 0 nothing.
  task automatic insn(input logic [31:0] a, input logic dra, input logic stp,
                      input dbg_exc_pkg::access_s ac, input logic [1:0] kind);
    if (kind != 2'h0) q.push_back({2'h1, 23'h0, kind[1], dbg_exc_pkg::VEC_DEBUG});
    insn_start <= 1'b1;
    insn_addr <= a;
    dbg_reg_access <= dra;
    acc <= ac;
    @(posedge clk_sys);
    insn_start <= 1'b0;
    dbg_reg_access <= 1'b0;
    acc <= '0;
    insn_done <= !kind[1];
    step_trap <= stp;
    @(posedge clk_sys);
    insn_done <= 1'b0;
    step_trap <= 1'b0;
    repeat (2) @(posedge clk_sys);
    dbg_exc_accept <= 1'b1;
    @(posedge clk_sys);
    dbg_exc_accept <= 1'b0;
    @(posedge clk_sys);
  endtask : insn

  task automatic rfl(input logic v);
    rf_load <= 1'b1;
    rf_load_value <= v;
    @(posedge clk_sys);
    rf_load <= 1'b0;
    @(posedge clk_sys);
  endtask : rfl

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rst_n, reg_wr, reg_rd, insn_start, ss_load_shadow, dbg_reg_access, insn_done} = '0;
    {rep_not_last, step_trap, task_trap, dbg_exc_accept, rf_load, rf_load_value} = '0;
    {reg_addr, reg_wdata, insn_addr, acc, rd_d, ent_d, exc_d} = '0;
    entry_kind = dbg_exc_pkg::EV_NONE;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(58439));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(dbg_exc_pkg::ADDR_STATUS, dbg_exc_pkg::STATUS_RESET);
    rd(dbg_exc_pkg::ADDR_CONTROL, dbg_exc_pkg::CONTROL_RESET);
    rd(dbg_exc_pkg::ADDR_RFLAG, 32'h0);
    rd(4'hF, 32'h0);
    $display("test reset values done");
    base = ($urandom & 32'h0FFFFFFC) | 32'h00001000;
    wr(dbg_exc_pkg::ADDR_SLOT0, base);
    wr(dbg_exc_pkg::ADDR_SLOT1, base + 32'h100);
    wr(dbg_exc_pkg::ADDR_SLOT2, base + 32'h200);
    wr(dbg_exc_pkg::ADDR_CONTROL, 32'h020D0015);
    insn(32'h40, 1'b0, 1'b0, '{1'b1, 1'b0, 1'b1, base + 32'h3, 4'h1}, 2'h1);
    rd(dbg_exc_pkg::ADDR_STATUS, 32'hFFFF0FF1);
    wr(dbg_exc_pkg::ADDR_STATUS, 32'h0);
    insn(32'h40, 1'b0, 1'b0, '{1'b1, 1'b0, 1'b0, base, 4'h4}, 2'h0);
    insn(32'h40, 1'b0, 1'b1, '{1'b1, 1'b0, 1'b1, base - 32'h1, 4'h2}, 2'h1);
    rd(dbg_exc_pkg::ADDR_STATUS, 32'hFFFF4FF1);
    wr(dbg_exc_pkg::ADDR_STATUS, 32'h0);
    insn(32'h40, 1'b0, 1'b0, '{1'b1, 1'b1, 1'b0, base + 32'h200, 4'h1}, 2'h1);
    rd(dbg_exc_pkg::ADDR_STATUS, 32'hFFFF0FF4);
    wr(dbg_exc_pkg::ADDR_STATUS, 32'h0);
    $display("test data breakpoints done");
    insn(base + 32'h100, 1'b0, 1'b0, '0, 2'h2);
    rd(dbg_exc_pkg::ADDR_STATUS, 32'hFFFF0FF2);
    wr(dbg_exc_pkg::ADDR_STATUS, 32'h0);
    rfl(1'b1);
    insn(base + 32'h100, 1'b0, 1'b0, '{1'b1, 1'b0, 1'b1, base, 4'h1}, 2'h1);
    rd(dbg_exc_pkg::ADDR_STATUS, 32'hFFFF0FF1);
    wr(dbg_exc_pkg::ADDR_STATUS, 32'h0);
    ss_load_shadow <= 1'b1;
    insn(32'h40, 1'b0, 1'b0, '0, 2'h0);
    ss_load_shadow <= 1'b0;
    insn(base + 32'h100, 1'b0, 1'b0, '0, 2'h0);
    rd(dbg_exc_pkg::ADDR_STATUS, 32'hFFFF0FF0);
    $display("test instruction breakpoint done");
    r = 1'($urandom);
    rfl(r);
    for (int k = 1; k < 6; k++) begin
      p = 1'($urandom);
      e = (k == 1) || r || (p && (k == 3 || k == 4));
      q.push_back({2'h2, 31'h0, e});
      entry_kind <= dbg_exc_pkg::event_kind_e'(k);
      rep_not_last <= p;
      @(posedge clk_sys);
      entry_kind <= dbg_exc_pkg::EV_NONE;
      @(posedge clk_sys);
    end
    rep_not_last <= 1'b0;
    $display("test handler entry done");
    q.push_back({2'h1, 24'h0, dbg_exc_pkg::VEC_DEBUG});
    task_trap <= 1'b1;
    @(posedge clk_sys);
    task_trap <= 1'b0;
    insn(32'h80, 1'b0, 1'b0, '0, 2'h0);
    rd(dbg_exc_pkg::ADDR_STATUS, 32'hFFFF8FF0);
    wr(dbg_exc_pkg::ADDR_STATUS, 32'h0);
    $display("test task switch done");
    wr(dbg_exc_pkg::ADDR_CONTROL, 32'h020D2015);
    q.push_back({2'h3, 32'h1});
    wr(dbg_exc_pkg::ADDR_SLOT0, 32'h0);
    insn(32'h40, 1'b1, 1'b0, '0, 2'h2);
    rd(dbg_exc_pkg::ADDR_STATUS, 32'hFFFF2FF0);
    rd(dbg_exc_pkg::ADDR_SLOT0, base);
    rst_n <= 1'b0;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(dbg_exc_pkg::ADDR_CONTROL, dbg_exc_pkg::CONTROL_RESET);
    $display("test guard and second reset done");
    give_verdict();
  end
endmodule : dbg_exc_unit_tb
